/* src/svr_consts.vh */
`ifndef SVR_CONSTS_VH
`define SVR_CONSTS_VH

// register offsets
`define SVR_ADDR_SPEED_CFG 8'h3e
`define SVR_ADDR_RECAL_REQ 8'h3f

// reset values
`define SVR_RST_SPEED_CFG 8'hc5
`define SVR_RST_RECAL_REQ 8'h00

// field positions in the speed config register
`define SVR_ACC_EN_BIT 7
`define SVR_CAP_HI 6
`define SVR_CAP_LO 4
`define SVR_WIN_HI 3
`define SVR_WIN_LO 2
`define SVR_SCALE_HI 1
`define SVR_SCALE_LO 0

// recal request layout
`define SVR_GROUP_BIT 7

// timing: clock rate and the one millisecond tick
`define SVR_CLK_HZ 100000000
`define SVR_MS_PER_SEC 1000
`define SVR_MS_TICK_CYCLES (`SVR_CLK_HZ / `SVR_MS_PER_SEC)

// fast-slide window durations in ms
`define SVR_WIN_MS_0 10'd350
`define SVR_WIN_MS_1 10'd560
`define SVR_WIN_MS_2 10'd770
`define SVR_WIN_MS_3 10'd980

// speed measurement interval in ms
`define SVR_SPEED_MS 7'd100

// repeat intervals in measurement cycles
`define SVR_RPT_35 8'd35
`define SVR_RPT_70 8'd70
`define SVR_RPT_105 8'd105
`define SVR_RPT_140 8'd140

`endif

/* src/svr_base_mem.v */
`include "svr_consts.vh"

// small base count store, one word per recal channel
module svr_base_mem #(
  parameter DATA_W = 16,
  parameter ADDR_W = 3
) (
  input wire clock_in,
  input wire reset_in,
  input wire wr_en_in,
  input wire [ADDR_W-1:0] wr_addr_in,
  input wire [DATA_W-1:0] wr_data_in,
  input wire [ADDR_W-1:0] rd_addr_in,
  output reg [DATA_W-1:0] rd_data_out
);

  reg [DATA_W-1:0] mem_q [0:(1<<ADDR_W)-1];

  // storage has no reset; only the read register is cleared
  always @(posedge clock_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  // registered read keeps the output straight from a flip-flop
  always @(posedge clock_in) begin
    if (reset_in) begin
      rd_data_out <= {DATA_W{1'b0}};
    end else begin
      rd_data_out <= mem_q[rd_addr_in];
    end
  end

endmodule

/* src/svr_top.v */
`include "svr_consts.vh"

// slider acceleration and forced recalibration control
module svr_top #(
  parameter MS_TICK_CYCLES = `SVR_MS_TICK_CYCLES,
  parameter BASE_W = 16
) (
  input wire clock_in,
  input wire reset_in,
  // register access from the serial management engine
  input wire reg_wr_en_in,
  input wire reg_rd_en_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  output reg [7:0] reg_rdata_out,
  // slider activity from the sensing logic
  input wire meas_tick_in,
  input wire slide_start_in,
  input wire slide_step_in,
  input wire slide_end_in,
  input wire slider_touch_in,
  input wire [7:0] slider_repeat_interval_in,
  input wire ordinary_slider_irq_in,
  output reg slider_irq_out,
  // calibration engine handshake
  output reg [7:0] recal_start_out,
  input wire recal_done_valid_in,
  input wire [2:0] recal_done_chan_in,
  input wire [BASE_W-1:0] recal_base_in,
  // base count lookup for touch detection
  input wire [2:0] base_rd_addr_in,
  output wire [BASE_W-1:0] base_rd_data_out
);

  localparam CNT_W = 17;
  // the tick count is worked out at full width, then cut to the counter width on purpose
  localparam [31:0] MS_LAST_W32 = MS_TICK_CYCLES - 1;
  localparam [CNT_W-1:0] MS_LAST = MS_LAST_W32[CNT_W-1:0];

  // repeat engine states
  localparam [1:0] RPT_IDLE = 2'd0;
  localparam [1:0] RPT_RUN = 2'd1;
  localparam [1:0] RPT_FIRE = 2'd2;

  reg [7:0] speed_cfg_q;
  reg [7:0] recal_req_q;
  reg [7:0] recal_req_d;
  reg [7:0] recal_start_d;
  reg [CNT_W-1:0] ms_cnt_q;
  reg ms_tick_q;
  reg sliding_q;
  reg [9:0] slide_ms_q;
  reg [6:0] speed_ms_q;
  reg [3:0] step_cnt_q;
  reg [3:0] speed_q;
  reg [2:0] extra_left_q;
  reg [2:0] extra_d;
  reg [1:0] rpt_state_q;
  reg [7:0] rpt_cnt_q;
  reg [7:0] rpt_interval;
  reg rpt_fire;
  reg extra_fire;

  wire acc_en = speed_cfg_q[`SVR_ACC_EN_BIT];
  wire [2:0] cap = speed_cfg_q[`SVR_CAP_HI:`SVR_CAP_LO];
  wire [1:0] win_code = speed_cfg_q[`SVR_WIN_HI:`SVR_WIN_LO];
  wire [1:0] scale = speed_cfg_q[`SVR_SCALE_HI:`SVR_SCALE_LO];
  wire [9:0] win_ms = win_len(win_code);
  wire [9:0] win_half = {1'b0, win_ms[9:1]};
  wire [9:0] win_3q = win_ms - {2'b00, win_ms[9:2]};
  wire wr_speed = reg_wr_en_in && (reg_addr_in == `SVR_ADDR_SPEED_CFG);
  wire wr_recal = reg_wr_en_in && (reg_addr_in == `SVR_ADDR_RECAL_REQ);

  // window code to duration in ms
  function [9:0] win_len;
    input [1:0] code;
    begin
      case (code)
        2'b00: win_len = `SVR_WIN_MS_0;
        2'b01: win_len = `SVR_WIN_MS_1;
        2'b10: win_len = `SVR_WIN_MS_2;
        default: win_len = `SVR_WIN_MS_3;
      endcase
    end
  endfunction

  // repeat interval table by sensors per interval and scale code
  function [7:0] rpt_pick;
    input [3:0] sensors;
    input [1:0] sc;
    input [7:0] normal;
    begin
      if (sensors >= 4'd5) begin
        rpt_pick = `SVR_RPT_35;
      end else if (sensors == 4'd4) begin
        rpt_pick = (sc == 2'b11) ? `SVR_RPT_70 : `SVR_RPT_35;
      end else if (sensors == 4'd3) begin
        case (sc)
          2'b10: rpt_pick = `SVR_RPT_70;
          2'b11: rpt_pick = `SVR_RPT_105;
          default: rpt_pick = `SVR_RPT_35;
        endcase
      end else if (sensors == 4'd2) begin
        case (sc)
          2'b00: rpt_pick = `SVR_RPT_35;
          2'b01: rpt_pick = `SVR_RPT_70;
          2'b10: rpt_pick = `SVR_RPT_105;
          default: rpt_pick = `SVR_RPT_140;
        endcase
      end else begin
        rpt_pick = normal;
      end
    end
  endfunction

  // register writes; reserved bits do not exist, all eight are live
  always @(posedge clock_in) begin
    if (reset_in) begin
      speed_cfg_q <= `SVR_RST_SPEED_CFG;
    end else if (wr_speed) begin
      speed_cfg_q <= reg_wdata_in;
    end
  end

  // read data registered one cycle after the strobe; unmapped reads zero
  always @(posedge clock_in) begin
    if (reset_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_en_in) begin
      case (reg_addr_in)
        `SVR_ADDR_SPEED_CFG: reg_rdata_out <= speed_cfg_q;
        `SVR_ADDR_RECAL_REQ: reg_rdata_out <= recal_req_q;
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // recal request bits: written ones start a routine unless that bit is already pending, done clears
  always @* begin
    recal_req_d = recal_req_q;
    recal_start_d = 8'h00;
    if (recal_done_valid_in) begin
      // done index 7 is the group, index i is channel i+1
      recal_req_d[recal_done_chan_in] = 1'b0;
    end
    if (wr_recal) begin
      // a fresh request wins over a same-cycle finish so it is not lost;
      // it is judged against the bits left after that finish, so it also starts
      recal_start_d = reg_wdata_in & ~recal_req_d;
      recal_req_d = recal_req_d | reg_wdata_in;
    end
  end

  always @(posedge clock_in) begin
    if (reset_in) begin
      recal_req_q <= `SVR_RST_RECAL_REQ;
      recal_start_out <= 8'h00;
    end else begin
      recal_req_q <= recal_req_d;
      recal_start_out <= recal_start_d;
    end
  end

  // a finished recal overwrites the base count used for detection
  svr_base_mem #(
    .DATA_W(BASE_W),
    .ADDR_W(3)
  ) u_base (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .wr_en_in(recal_done_valid_in),
    .wr_addr_in(recal_done_chan_in),
    .wr_data_in(recal_base_in),
    .rd_addr_in(base_rd_addr_in),
    .rd_data_out(base_rd_data_out)
  );

  // one millisecond tick; slide timing is coarse, so ms resolution is enough
  always @(posedge clock_in) begin
    if (reset_in) begin
      ms_cnt_q <= {CNT_W{1'b0}};
      ms_tick_q <= 1'b0;
    end else if (ms_cnt_q == MS_LAST) begin
      ms_cnt_q <= {CNT_W{1'b0}};
      ms_tick_q <= 1'b1;
    end else begin
      ms_cnt_q <= ms_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      ms_tick_q <= 1'b0;
    end
  end

  // slide duration in ms, saturating at 1023, just above the longest window of 980
  always @(posedge clock_in) begin
    if (reset_in) begin
      sliding_q <= 1'b0;
      slide_ms_q <= 10'd0;
    end else if (slide_start_in) begin
      sliding_q <= 1'b1;
      slide_ms_q <= 10'd0;
    end else if (slide_end_in) begin
      sliding_q <= 1'b0;
    end else if (sliding_q && ms_tick_q && (slide_ms_q != 10'h3ff)) begin
      slide_ms_q <= slide_ms_q + 10'd1;
    end
  end

  // speed: sensors stepped over within each 100 ms interval
  always @(posedge clock_in) begin
    if (reset_in || slide_start_in) begin
      speed_ms_q <= 7'd0;
      step_cnt_q <= {3'b000, slide_start_in};
      speed_q <= 4'd0;
    end else if (ms_tick_q && (speed_ms_q == `SVR_SPEED_MS - 7'd1)) begin
      speed_ms_q <= 7'd0;
      speed_q <= step_cnt_q;
      step_cnt_q <= {3'b000, slide_step_in};
    end else begin
      if (ms_tick_q) begin
        speed_ms_q <= speed_ms_q + 7'd1;
      end
      if (slide_step_in && (step_cnt_q != 4'hf)) begin
        step_cnt_q <= step_cnt_q + 4'd1;
      end
    end
  end

  // number of extras earned by the slide that just ended
  always @* begin
    if (!acc_en || (slide_ms_q > win_ms)) begin
      extra_d = 3'd0;
    end else if (slide_ms_q < win_half) begin
      extra_d = cap;
    end else if (slide_ms_q < win_3q) begin
      extra_d = {1'b0, cap[2:1]};
    end else begin
      extra_d = {2'b00, cap[2]};
    end
  end

  // extras are paced one per measurement cycle after the slide ends
  always @(posedge clock_in) begin
    if (reset_in || !acc_en || slide_start_in) begin
      extra_left_q <= 3'd0;
    end else if (slide_end_in && sliding_q) begin
      extra_left_q <= extra_d;
    end else if (meas_tick_in && (extra_left_q != 3'd0)) begin
      extra_left_q <= extra_left_q - 3'd1;
    end
  end

  always @* begin
    extra_fire = meas_tick_in && (extra_left_q != 3'd0) && acc_en && !slide_end_in;
    rpt_interval = rpt_pick(speed_q, scale, slider_repeat_interval_in);
  end

  // repeat engine counts measurement cycles while the slider is held
  always @(posedge clock_in) begin
    if (reset_in) begin
      rpt_state_q <= RPT_IDLE;
      rpt_cnt_q <= 8'd0;
    end else begin
      case (rpt_state_q)
        RPT_IDLE: begin
          rpt_cnt_q <= 8'd0;
          if (sliding_q && slider_touch_in) begin
            rpt_state_q <= RPT_RUN;
          end
        end
        RPT_RUN: begin
          if (!sliding_q || !slider_touch_in) begin
            rpt_state_q <= RPT_IDLE;
          end else if (meas_tick_in) begin
            if (rpt_cnt_q + 8'd1 >= rpt_interval) begin
              rpt_state_q <= RPT_FIRE;
            end
            rpt_cnt_q <= rpt_cnt_q + 8'd1;
          end
        end
        RPT_FIRE: begin
          rpt_cnt_q <= 8'd0;
          rpt_state_q <= RPT_RUN;
        end
        default: begin
          rpt_state_q <= RPT_IDLE;
        end
      endcase
    end
  end

  always @* begin
    rpt_fire = (rpt_state_q == RPT_FIRE);
  end

  // all slider sources merge onto one pulse, indistinguishable to the host
  always @(posedge clock_in) begin
    if (reset_in) begin
      slider_irq_out <= 1'b0;
    end else begin
      slider_irq_out <= ordinary_slider_irq_in | extra_fire | rpt_fire;
    end
  end

endmodule

/* test/svr_top_monitor.sv */
module svr_top_monitor #(
  parameter int BASE_W = 16
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic reg_wr_en_in,
  input wire logic reg_rd_en_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic meas_tick_in,
  input wire logic ordinary_slider_irq_in,
  input wire logic slider_irq_out,
  input wire logic [7:0] recal_start_out,
  input wire logic recal_done_valid_in,
  input wire logic [2:0] recal_done_chan_in,
  input wire logic [BASE_W-1:0] recal_base_in,
  input wire logic [2:0] base_rd_addr_in,
  input wire logic [BASE_W-1:0] base_rd_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  // start pulses only for bits just written as one; group and channel 1 starts last only one cycle
  property p_start;
    |recal_start_out |-> $past(reg_wr_en_in) && $past(reg_addr_in) == 8'h3f &&
      (recal_start_out & ~$past(reg_wdata_in)) == 8'h00;
  endproperty
  a_start: assert property (p_start) else $error("start without request");
  property p_grp_pulse;
    recal_start_out[7] |=> !recal_start_out[7];
  endproperty
  a_grp_pulse: assert property (p_grp_pulse) else $error("group start held");
  property p_ch1_pulse;
    recal_start_out[0] |=> !recal_start_out[0];
  endproperty
  a_ch1_pulse: assert property (p_ch1_pulse) else $error("chan1 start held");
  // unmapped reads give zero; a written config byte reads back
  property p_unmapped;
    reg_rd_en_in && reg_addr_in != 8'h3e && reg_addr_in != 8'h3f |=> reg_rdata_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_cfg_rw;
    reg_wr_en_in && reg_addr_in == 8'h3e ##1 !reg_wr_en_in ##1 reg_rd_en_in &&
      reg_addr_in == 8'h3e |=> reg_rdata_out == $past(reg_wdata_in, 3);
  endproperty
  a_cfg_rw: assert property (p_cfg_rw) else $error("config readback");
  // every merged pulse has a tick or an ordinary request just behind it
  property p_irq_cause;
    slider_irq_out |-> $past(meas_tick_in) || $past(meas_tick_in, 2) ||
      $past(ordinary_slider_irq_in) || $past(ordinary_slider_irq_in, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("pulse without cause");
  property p_ordinary;
    ordinary_slider_irq_in |-> ##[1:2] slider_irq_out;
  endproperty
  a_ordinary: assert property (p_ordinary) else $error("ordinary lost");
  // the base count of a finished routine is what the lookup returns next
  property p_base;
    recal_done_valid_in ##1 base_rd_addr_in == $past(recal_done_chan_in) |=>
      base_rd_data_out == $past(recal_base_in, 2);
  endproperty
  a_base: assert property (p_base) else $error("base not replaced");
endmodule
bind svr_top svr_top_monitor #(.BASE_W(BASE_W)) u_svr_top_monitor (.*);

/* test/svr_cal_model.sv */
module svr_cal_model #(
  parameter int DLY = 8
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [7:0] start_in,
  output logic done_out,
  output logic [2:0] chan_out,
  output logic [15:0] base_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] pend_q;
  int cnt_q;
  int k;
  // one routine at a time, lowest index first; idle lines keep changing
  always @(posedge clock_in) begin
    k = 8;
    for (int i = 7; i >= 0; i--) if (pend_q[i]) k = i;
    done_out <= 1'b0;
    chan_out <= 3'(cnt_q);
    base_out <= ~base_out;
    cnt_q <= (k == 8 || cnt_q == DLY) ? 0 : cnt_q + 1;
    pend_q <= pend_q | start_in;
    if (k < 8 && cnt_q == DLY) begin
      done_out <= 1'b1;
      chan_out <= 3'(k);
      base_out <= 16'h0b00 + 16'(k);
      pend_q <= (pend_q | start_in) & ~(8'h01 << k);
    end
    if (reset_in) begin
      pend_q <= 8'h00;
      cnt_q <= 0;
      base_out <= 16'h5a5a;
    end
  end
endmodule

/* test/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 1'h0, reset_in = 1'h1, reg_wr_en_in = 1'h0, reg_rd_en_in = 1'h0;
  logic meas_tick_in = 1'h0, slide_start_in = 1'h0, slide_step_in = 1'h0;
  logic slide_end_in = 1'h0, slider_touch_in = 1'h0, ordinary_slider_irq_in = 1'h0;
  logic recal_done_valid_in, slider_irq_out;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, recal_start_out;
  logic [7:0] slider_repeat_interval_in = 8'h14;
  logic [2:0] recal_done_chan_in, base_rd_addr_in = 3'h0;
  logic [15:0] recal_base_in, base_rd_data_out;
  int n_mismatch = 0, tests_run = 0, irqs = 0, ticks = 0, last_t = 0, gap = 0;
  `define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
  svr_top #(.MS_TICK_CYCLES(10), .BASE_W(16)) u_svr_top (.clock_in(clock_in),
    .reset_in(reset_in), .reg_wr_en_in(reg_wr_en_in), .reg_rd_en_in(reg_rd_en_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .meas_tick_in(meas_tick_in), .slide_start_in(slide_start_in),
    .slide_step_in(slide_step_in), .slide_end_in(slide_end_in),
    .slider_touch_in(slider_touch_in), .slider_repeat_interval_in(slider_repeat_interval_in),
    .ordinary_slider_irq_in(ordinary_slider_irq_in), .slider_irq_out(slider_irq_out),
    .recal_start_out(recal_start_out), .recal_done_valid_in(recal_done_valid_in),
    .recal_done_chan_in(recal_done_chan_in), .recal_base_in(recal_base_in),
    .base_rd_addr_in(base_rd_addr_in), .base_rd_data_out(base_rd_data_out));
  svr_cal_model u_svr_cal_model (.clock_in(clock_in), .reset_in(reset_in),
    .start_in(recal_start_out), .done_out(recal_done_valid_in),
    .chan_out(recal_done_chan_in), .base_out(recal_base_in));
  initial forever #5 clock_in = ~clock_in;
  // count pulses and the tick spacing between them, whatever the latency
  always @(posedge clock_in) begin
    ticks += int'(meas_tick_in === 1'b1);
    if (slider_irq_out === 1'b1) begin
      irqs++;
      gap = ticks - last_t;
      last_t = ticks;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_wr_en_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_wr_en_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in);
    reg_rd_en_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clock_in);
    reg_rd_en_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  // one-cycle pulse: 0 start, 1 step, 2 end, 3 ordinary, 4 tick
  task automatic pulse(input int w);
    @(posedge clock_in);
    {meas_tick_in, ordinary_slider_irq_in, slide_end_in, slide_step_in, slide_start_in}
      <= 5'h01 << w;
    @(posedge clock_in);
    {meas_tick_in, ordinary_slider_irq_in, slide_end_in, slide_step_in, slide_start_in}
      <= 5'h00;
  endtask
  task automatic t_regs;
    logic [7:0] d;
    rd(8'h3e, d);
    `CHK("cfg reset", 8'hc5, d)
    rd(8'h3f, d);
    `CHK("recal reset", 8'h00, d)
    wr(8'h40, 8'hff);
    rd(8'h40, d);
    `CHK("unmapped", 8'h00, d)
    wr(8'h3e, 8'h3a);
    rd(8'h3e, d);
    `CHK("cfg readback", 8'h3a, d)
  endtask
  // each request bit: start, refused repeat, self-clear, new base count
  task automatic t_recal;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      wr(8'h3f, 8'h01 << i);
      base_rd_addr_in <= 3'(i);
      #1 `CHK("start", 8'h01 << i, recal_start_out)
      rd(8'h3f, d);
      `CHK("bit held", 8'h01 << i, d)
      wr(8'h3f, 8'h01 << i);
      #1 `CHK("no restart", 8'h00, recal_start_out)
      for (int k = 0; k < 40 && d != 8'h00; k++) rd(8'h3f, d);
      `CHK("bit cleared", 8'h00, d)
      if (d != 8'h00) stop_test();
      @(posedge clock_in);
      #1 `CHK("new base", 16'h0b00 + 16'(i), base_rd_data_out)
    end
  endtask
  task automatic t_ord;
    int n0;
    #1 n0 = irqs;
    pulse(3);
    repeat (3) @(posedge clock_in);
    #1 `CHK("ordinary", 1, irqs - n0)
  endtask
  task automatic t_extras(input logic [7:0] cfg, input int ms, input int exp);
    int n0;
    wr(8'h3e, cfg);
    pulse(0);
    repeat (ms * 10 - 2) @(posedge clock_in);
    pulse(2);
    #1 n0 = irqs;
    repeat (10) pulse(4);
    repeat (3) @(posedge clock_in);
    #1 `CHK("extras", exp, irqs - n0)
  endtask
  // extras off here, so only the repeat logic pulses while touched
  task automatic t_rpt(input logic [1:0] sc, input int s, input int exp);
    int n0;
    wr(8'h3e, {6'h11, sc});
    pulse(0);
    repeat (s - 1) pulse(1);
    repeat (1050 - 2 * s) @(posedge clock_in);
    slider_touch_in <= 1'b1;
    gap = 0;
    #1 n0 = irqs;
    for (int k = 0; k < 400 && irqs < n0 + 2; k++) pulse(4);
    if (irqs < n0 + 2) begin
      n_mismatch++;
      $display("CHECK FAILED repeat pulses exp 2 got %0d", irqs - n0);
      stop_test();
    end
    `CHK("repeat gap", exp, gap)
    slider_touch_in <= 1'b0;
    pulse(2);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    logic [7:0] cf[9] = '{8'hf1, 8'hf1, 8'hf1, 8'hf1, 8'h71, 8'h81, 8'he9, 8'hdd, 8'hc5};
    int ms[9] = '{100, 200, 300, 400, 100, 100, 300, 600, 500};
    int ex[9] = '{7, 3, 1, 0, 0, 0, 6, 2, 1};
    logic [1:0] sc[7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h1};
    int ns[7] = '{5, 2, 3, 4, 3, 2, 1};
    int nr[7] = '{35, 70, 70, 70, 105, 140, 20};
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    t_regs();
    t_recal();
    t_ord();
    foreach (cf[i]) t_extras(cf[i], ms[i], ex[i]);
    foreach (sc[i]) t_rpt(sc[i], ns[i], nr[i]);
    stop_test();
  end
endmodule
